/* verilog/htcb_pkg.sv */
// Package of offsets, field layouts, reset values and timing counts for the timer and counter bank
package htcb_pkg;
  // Register offsets (byte addresses on the host bus)
  localparam logic [7:0] OFF_TIMER_CFG = 8'h8C;
  localparam logic [7:0] OFF_TIMER_CNT = 8'h90;
  localparam logic [7:0] OFF_BYTE_ORDER = 8'h98;
  localparam logic [7:0] OFF_CYCLE_TICK = 8'h9C;
  localparam logic [7:0] OFF_DROP_CNT = 8'hA0;
  // Field positions
  localparam int TIMER_EN_BIT = 29;
  localparam int PRELOAD_MSB = 15;
  // Reset values and compare constants
  localparam logic [15:0] PRELOAD_RST = 16'hFFFF;
  localparam logic [15:0] TIMER_CNT_RST = 16'hFFFF;
  localparam logic [31:0] BYTE_ORDER_RST = 32'h0000_0000;
  localparam logic [31:0] BIG_ENDIAN_KEY = 32'hFFFF_FFFF;
  localparam logic [31:0] DROP_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] DROP_MIDPOINT = 32'h8000_0000;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 40;
  localparam int TICK_DIV = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CLEAR_MAX_NS = 160;
  localparam int CLEAR_MAX_CYC = CLEAR_MAX_NS / CLK_PERIOD_NS;
  localparam int TIMER_TICK_US = 100;
  localparam int TIMER_TICK_DIV = TIMER_TICK_US * 1000 / CLK_PERIOD_NS;

  // One host access: byte address, strobes, data and half select
  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic hi_half;
    logic [15:0] wdata;
  } htcb_acc_t;

  // Timer state: halted or running, decoded from the run flag alone
  typedef enum logic [1:0] {
    HTCB_HALTED = 2'b00,
    HTCB_RUNNING = 2'b01
  } htcb_tmr_st_t;
endpackage

/* verilog/htcb_divider.sv */
// Cycle divider producing one-cycle enable pulses
`timescale 1ns/1ps
module htcb_divider #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pulse out
  output logic o_tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q;
  wire at_end = (cnt_q == LAST);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= at_end ? '0 : cnt_q + W'(1);
      o_tick <= at_end;
    end
  end
endmodule

/* verilog/htcb_bank.sv */
// Host timer and counter register bank on a 16-bit host bus
// Behaviour
// [RL1] Run bit set runs timer, clear halts
// [RL2] Run falling edge forces preload to FFFF
// [RL3] Preload field is timer start count
// [RL4] Count register reads live timer, resets FFFF
// [RL5] Timer raises periodic interrupt per preload
// [RL6] All-ones byte-order word selects big-endian
// [RL7] Byte order only matters in 16-bit mode
// [RL8] Free counter from zero, +1 each 25MHz
// [RL9] Free counter wraps to zero at max
// [RL10] Full count latched on first half read
// [RL11] Free counter clears within 160ns after reset
// [RL12] Free counter runs in every power state
// [RL13] Drop counter increments per dropped frame
// [RL14] Drop counter read returns value, then clears
// [RL15] Drop counter crossing 80000000h raises event
// [RL16] Timer decrements per tick, reloads on wrap
// [RL17] Reserved bits read zero, writes ignored
`timescale 1ns/1ps
module htcb_bank #(
  parameter int TIMER_TICK_DIV = htcb_pkg::TIMER_TICK_DIV
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host bus, 16-bit half-word access to 32-bit registers
  input wire logic [7:0] i_addr,
  input wire logic i_hi_half,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // Configuration and events
  input wire logic i_bus16,
  input wire logic i_frame_drop,
  output logic o_big_endian,
  output logic o_timer_irq,
  output logic o_drop_half_irq
);
  htcb_pkg::htcb_acc_t acc;
  assign acc = '{addr: i_addr, rd: i_rd, wr: i_wr, hi_half: i_hi_half, wdata: i_wdata};

  // One compare shape serves every register offset
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
  begin
    reg_hit = (a == off);
  end
  endfunction

  // Half-word pick from a 32-bit register image
  function automatic logic [15:0] half_pick(input logic [31:0] word, input logic hi);
  begin
    half_pick = hi ? word[31:16] : word[15:0];
  end
  endfunction

  // Address decode
  wire sel_cfg = reg_hit(acc.addr, htcb_pkg::OFF_TIMER_CFG);
  wire sel_cnt = reg_hit(acc.addr, htcb_pkg::OFF_TIMER_CNT);
  wire sel_bo = reg_hit(acc.addr, htcb_pkg::OFF_BYTE_ORDER);
  wire sel_free = reg_hit(acc.addr, htcb_pkg::OFF_CYCLE_TICK);
  wire sel_drop = reg_hit(acc.addr, htcb_pkg::OFF_DROP_CNT);

  // Access strobes that have side effects
  wire cfg_wr_lo = acc.wr && sel_cfg && !acc.hi_half;
  wire cfg_wr_hi = acc.wr && sel_cfg && acc.hi_half;
  wire bo_wr_lo = acc.wr && sel_bo && !acc.hi_half;
  wire bo_wr_hi = acc.wr && sel_bo && acc.hi_half;
  wire free_rd_lo = acc.rd && sel_free && !acc.hi_half;
  wire drop_rd_lo = acc.rd && sel_drop && !acc.hi_half;

  // Slow enables
  logic tick25;
  logic ttick;
  htcb_divider #(.DIV(htcb_pkg::TICK_DIV)) u_div25 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_tick(tick25)
  );
  htcb_divider #(.DIV(TIMER_TICK_DIV)) u_divt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_tick(ttick)
  );

  // Timer configuration
  logic run_q;
  logic [15:0] preload_q;
  logic [15:0] timer_q;
  logic [15:0] timer_d;
  htcb_pkg::htcb_tmr_st_t st;
  assign st = run_q ? htcb_pkg::HTCB_RUNNING : htcb_pkg::HTCB_HALTED;
  wire run_d = cfg_wr_hi ? acc.wdata[htcb_pkg::TIMER_EN_BIT - 16] : run_q; // [RL1]
  wire run_fall = run_q && !run_d;
  wire timer_wrap = (st == htcb_pkg::HTCB_RUNNING) && ttick && (timer_q == 16'h0000);
  // Halt only comes from a high-half write, so it never meets a preload write
  wire [15:0] preload_d = run_fall ? htcb_pkg::PRELOAD_RST : // [RL2]
                          cfg_wr_lo ? acc.wdata[htcb_pkg::PRELOAD_MSB:0] : preload_q; // [RL3]

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      run_q <= 1'b0;
    else
      run_q <= run_d; // [RL1]
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      preload_q <= htcb_pkg::PRELOAD_RST;
    else
      preload_q <= preload_d; // [RL2] [RL3]
  end

  // Timer loads preload on start, counts down, reloads on wrap
  always_comb
  begin
    timer_d = timer_q;
    unique case (st)
      htcb_pkg::HTCB_HALTED:
      begin
        if (run_d)
          timer_d = preload_q; // [RL1] [RL3]
      end
      htcb_pkg::HTCB_RUNNING:
      begin
        if (timer_wrap)
          timer_d = preload_q; // [RL16]
        else if (ttick)
          timer_d = timer_q - 16'h0001; // [RL16]
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      timer_q <= htcb_pkg::TIMER_CNT_RST; // [RL4]
    else
      timer_q <= timer_d;
  end

  // Timer interrupt pulses once per wrap, giving a period set by the preload
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_timer_irq <= 1'b0;
    else
      o_timer_irq <= timer_wrap; // [RL5]
  end

  // Byte order word
  logic [31:0] bo_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      bo_q <= htcb_pkg::BYTE_ORDER_RST;
    else if (bo_wr_hi)
      bo_q[31:16] <= acc.wdata;
    else if (bo_wr_lo)
      bo_q[15:0] <= acc.wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_big_endian <= 1'b0;
    else
      o_big_endian <= i_bus16 && (bo_q == htcb_pkg::BIG_ENDIAN_KEY); // [RL6] [RL7]
  end

  // Free-running counter: no power-state gating, runs on reset release
  logic [31:0] free_q;
  logic [31:0] free_latch_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      free_q <= 32'h0000_0000; // [RL8] [RL11]
    else if (tick25)
      free_q <= free_q + 32'h0000_0001; // [RL8] [RL9] [RL12]
  end

  // Low half read latches the whole count; high half returns the latched part
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      free_latch_q <= 32'h0000_0000;
    else if (free_rd_lo)
      free_latch_q <= free_q; // [RL10]
  end

  // Dropped-frame tally; a drop in the clearing read's cycle counts as one
  logic [31:0] drop_q;
  logic [31:0] drop_latch_q;
  wire [31:0] drop_inc = drop_q + 32'h0000_0001;
  wire [31:0] drop_d = drop_rd_lo ? (i_frame_drop ? 32'h0000_0001 : htcb_pkg::DROP_CNT_RST) : // [RL14]
                       i_frame_drop ? drop_inc : drop_q; // [RL13]
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      drop_q <= htcb_pkg::DROP_CNT_RST;
    else
      drop_q <= drop_d; // [RL13] [RL14]
  end

  // The clearing read keeps the old count so the high half can follow it
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      drop_latch_q <= htcb_pkg::DROP_CNT_RST;
    else if (drop_rd_lo)
      drop_latch_q <= drop_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_drop_half_irq <= 1'b0;
    else
      o_drop_half_irq <= i_frame_drop && !drop_rd_lo && (drop_inc == htcb_pkg::DROP_MIDPOINT); // [RL15]
  end

  // Read mux; unused and reserved bits return zero
  wire [31:0] cfg_word = {2'b00, run_q, 13'h0000, preload_q}; // [RL17]
  wire [31:0] cnt_word = {16'h0000, timer_q}; // [RL4] [RL17]
  // High halves of both counters come from the copy that the low read took
  wire [31:0] free_word = {free_latch_q[31:16], free_q[15:0]}; // [RL10]
  wire [31:0] drop_word = {drop_latch_q[31:16], drop_q[15:0]};
  wire [15:0] rd_half = sel_cfg ? half_pick(cfg_word, acc.hi_half) :
                        sel_cnt ? half_pick(cnt_word, acc.hi_half) :
                        sel_bo ? half_pick(bo_q, acc.hi_half) :
                        sel_free ? half_pick(free_word, acc.hi_half) :
                        sel_drop ? half_pick(drop_word, acc.hi_half) : 16'h0000; // [RL17]

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else if (acc.rd)
      o_rdata <= rd_half;
  end
endmodule

/* testbench/htcb_host_model.sv */
// Host processor model issuing half-word register accesses
`timescale 1ns/1ps
module htcb_host_model (
  // Clock
  input wire logic i_clk,
  // Host bus
  output logic [7:0] o_addr,
  output logic o_hi_half,
  output logic o_rd,
  output logic o_wr,
  output logic [15:0] o_wdata
);
  initial
  begin
    {o_addr, o_hi_half, o_rd, o_wr, o_wdata} = '0;
  end
  // Strobes last one cycle; released data is inverted so stale values never match
  task automatic acc(input logic [7:0] a, input logic h, input logic w, input logic [15:0] d);
  begin
    @(posedge i_clk);
    o_addr <= a;
    o_hi_half <= h;
    o_rd <= !w;
    o_wr <= w;
    o_wdata <= d;
    @(posedge i_clk);
    {o_rd, o_wr} <= 2'b00;
    o_wdata <= ~d;
  end
  endtask
endmodule

/* testbench/htcb_bank_properties.sv */
// Port checker for the timer and counter bank
`timescale 1ns/1ps
module htcb_bank_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus and events
  input wire logic [7:0] i_addr,
  input wire logic i_hi_half,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  input wire logic i_bus16,
  input wire logic i_frame_drop,
  input wire logic o_big_endian,
  input wire logic o_timer_irq,
  input wire logic o_drop_half_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire rd_lo = i_rd && !i_hi_half;
  property p_unmap; i_rd && !(i_addr inside {8'h8C, 8'h90, 8'h98, 8'h9C, 8'hA0}) |=> o_rdata == 16'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_cnt_rst; $fell(i_rst) ##1 rd_lo && i_addr == 8'h90 |=> o_rdata == 16'hFFFF; endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("count reset value");
  property p_bus8; !i_bus16 ##1 !i_bus16 |-> !o_big_endian; endproperty
  a_bus8: assert property (p_bus8) else $error("big endian outside 16-bit mode");
  property p_irq_gap; o_timer_irq |=> !o_timer_irq [*3]; endproperty
  a_irq_gap: assert property (p_irq_gap) else $error("timer irq too close");
  property p_halt; i_wr && i_addr == 8'h8C && i_hi_half && !i_wdata[13] |=> ##2 !o_timer_irq [*8]; endproperty
  a_halt: assert property (p_halt) else $error("irq while halted");
  property p_drop_irq; o_drop_half_irq |-> $past(i_frame_drop) || $past(i_frame_drop, 2); endproperty
  a_drop_irq: assert property (p_drop_irq) else $error("drop event without drop");
  property p_clr; rd_lo && i_addr == 8'hA0 && !i_frame_drop ##1 !i_frame_drop ##1 rd_lo && i_addr == 8'hA0 |=> o_rdata == 16'h0; endproperty
  a_clr: assert property (p_clr) else $error("drop tally not cleared");
  property p_free; rd_lo && i_addr == 8'h9C ##4 rd_lo && i_addr == 8'h9C |=> o_rdata == $past(o_rdata, 4) + 16'h1; endproperty
  a_free: assert property (p_free) else $error("free count step");
endmodule
bind htcb_bank htcb_bank_properties i_chk (.*);

/* testbench/host_timer_counter_bank_tb_top.sv */
// Self-checking bench for the timer and counter bank
`timescale 1ns/1ps
module host_timer_counter_bank_tb_top;
  logic i_clk, i_rst, i_bus16, i_frame_drop, h, r, w, o_big_endian, o_timer_irq, o_drop_half_irq;
  logic [7:0] a;
  logic [15:0] d, o_rdata, v, f0;
  int bad_count, n_tests, i, j;
  htcb_host_model h_m (.i_clk(i_clk), .o_addr(a), .o_hi_half(h), .o_rd(r), .o_wr(w), .o_wdata(d));
  // Short timer tick keeps the periodic checks within a few dozen cycles
  htcb_bank #(.TIMER_TICK_DIV(4)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(a), .i_hi_half(h), .i_rd(r),
    .i_wr(w), .i_wdata(d), .o_rdata(o_rdata), .i_bus16(i_bus16), .i_frame_drop(i_frame_drop),
    .o_big_endian(o_big_endian), .o_timer_irq(o_timer_irq), .o_drop_half_irq(o_drop_half_irq));
  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
  begin
    n_tests++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task rd(input logic [7:0] ad, input logic hh);
  begin
    h_m.acc(ad, hh, 1'b0, 16'h0);
    #1 v = o_rdata;
  end
  endtask
  task rc(input logic [7:0] ad, input logic hh, input logic [15:0] e, input string n);
  begin
    rd(ad, hh);
    chk(n, v, e);
  end
  endtask
  task t_rst;
  begin
    rc(8'h90, 1'b0, 16'hFFFF, "count_rst");
    rc(8'h8C, 1'b0, 16'hFFFF, "preload_rst");
    h_m.acc(8'h00, 1'b0, 1'b1, 16'h1234);
    rc(8'h00, 1'b0, 16'h0, "unmapped");
  end
  endtask
  task t_order;
  begin
    h_m.acc(8'h98, 1'b0, 1'b1, 16'hFFFF);
    h_m.acc(8'h98, 1'b1, 1'b1, 16'hFFFF);
    rc(8'h98, 1'b1, 16'hFFFF, "order_hi");
    chk("big_endian", {15'h0, o_big_endian}, 16'h1);
    @(posedge i_clk) i_bus16 <= 0;
    repeat (3) @(posedge i_clk);
    #1 chk("bus8_order", {15'h0, o_big_endian}, 16'h0);
    @(posedge i_clk) i_bus16 <= 1;
    h_m.acc(8'h98, 1'b0, 1'b1, 16'hFFFE);
    rc(8'h98, 1'b0, 16'hFFFE, "order_lo");
    chk("little_endian", {15'h0, o_big_endian}, 16'h0);
  end
  endtask
  task t_timer;
  begin
    h_m.acc(8'h8C, 1'b0, 1'b1, 16'h0002);
    h_m.acc(8'h8C, 1'b1, 1'b1, 16'hFFFF);
    #1;
    for (i = 0; i < 40 && o_timer_irq !== 1'b1; i++) #10;
    chk("irq_seen", {15'h0, i < 40}, 16'h1);
    if (i == 40) end_of_test();
    #10;
    for (j = 1; j < 40 && o_timer_irq !== 1'b1; j++) #10;
    chk("irq_period", 16'(j), 16'd12);
    rc(8'h8C, 1'b1, 16'h2000, "run_bit");
    h_m.acc(8'h8C, 1'b1, 1'b1, 16'h0000);
    rc(8'h8C, 1'b0, 16'hFFFF, "halt_preload");
    rd(8'h90, 1'b0);
    #100 rc(8'h90, 1'b0, v, "count_held");
  end
  endtask
  task t_free;
  begin
    rd(8'h9C, 1'b0);
    f0 = v;
    #20 rd(8'h9C, 1'b0);
    chk("free_step", v - f0, 16'h1);
    rc(8'h9C, 1'b1, 16'h0, "free_hi");
  end
  endtask
  task t_drop;
  begin
    repeat (3)
    begin
      @(posedge i_clk) i_frame_drop <= 1;
      @(posedge i_clk) i_frame_drop <= 0;
    end
    rc(8'hA0, 1'b0, 16'h3, "drop_lo");
    chk("drop_half_irq", {15'h0, o_drop_half_irq}, 16'h0);
    rc(8'hA0, 1'b1, 16'h0, "drop_hi");
    rc(8'hA0, 1'b0, 16'h0, "drop_clr");
    rc(8'hA0, 1'b0, 16'h0, "drop_clr2");
  end
  endtask
  task t_mid_rst;
  begin
    @(posedge i_clk) i_rst <= 1;
    @(posedge i_clk) i_rst <= 0;
    rc(8'h9C, 1'b0, 16'h0, "free_rst");
    rc(8'h90, 1'b0, 16'hFFFF, "count_rst2");
  end
  endtask
  initial
  begin
    i_rst = 1;
    i_bus16 = 1;
    i_frame_drop = 0;
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    t_rst();
    t_order();
    t_timer();
    t_free();
    t_drop();
    t_mid_rst();
    end_of_test();
  end
endmodule
